// ==== src/ntf_pkg.sv ====
// shared constants and carrier types for the target field configuration bank
// How it works
// - collision level register clears at power-on and while enable is low
// - collision level bit 7 disables the clock extractor
// - collision bits 2..0 set threshold; comparator shows in status bit 6
// - identifier register stores card or target identifier bytes
// - length field 00=4, 01=7, 10=10 bytes, 11 prohibited
// - wake-up bit 5 enables automatic single-device detection using identifier
// - wake-up bit 3 selects extended rf measurement range
// - wake-up bits 2..0 set wake threshold; zero turns detection off
// - wake-up register survives power-down; cleared only by main supply power-up
// - status bits 7 and 6 follow comparators live, never latched
// - interrupt status 0x04 on field detect, 0x08 on detection done
package ntf_pkg;
  localparam logic [7:0] NTF_OFS_COLL = 8'h16;
  localparam logic [7:0] NTF_OFS_ID = 8'h17;
  localparam logic [7:0] NTF_OFS_WAKE = 8'h18;
  localparam logic [7:0] NTF_OFS_STAT = 8'h19;
  localparam logic [7:0] NTF_RST_COLL = 8'h00;
  localparam logic [7:0] NTF_RST_WAKE = 8'h00;
  localparam int NTF_BIT_CLEX = 7;
  localparam int NTF_BIT_LEN_HI = 7;
  localparam int NTF_BIT_LEN_LO = 6;
  localparam int NTF_BIT_SDD = 5;
  localparam int NTF_BIT_HIRF = 3;
  localparam int NTF_BIT_WAKE_CMP = 7;
  localparam int NTF_BIT_COLL_CMP = 6;
  localparam int NTF_ID_MAX = 10;
  localparam logic [7:0] NTF_IRQ_FIELD = 8'h04;
  localparam logic [7:0] NTF_IRQ_SDD = 8'h08;
  typedef struct packed {
    logic wr;         // write strobe, one cycle
    logic rd;         // read strobe, one cycle
    logic cont;       // continuous-mode burst in progress
    logic [7:0] addr; // register address
    logic [7:0] data; // write data
  } ntf_req_s;
  typedef struct packed {
    logic clex_dis;
    logic [2:0] coll_lvl;
    logic sdd_en;
    logic extended_rf_range;
    logic [2:0] wake_lvl;
    logic [3:0] id_bytes;
  } ntf_cfg_s;
endpackage

// ==== src/ntf_top.sv ====
// target field configuration register bank
`timescale 1ns/1ns
module ntf_top (
  input wire logic clk_i,                     // 125 MHz core clock
  input wire logic rst_i,                     // main supply power-on reset
  input wire logic core_por_i,                // core supply power-on reset, sync
  input wire logic chip_en_i,                 // chip enable pin, async
  input wire logic ce_i,                      // clock enable
  input wire ntf_pkg::ntf_req_s req_i,        // host register access
  input wire logic wakeup_comparator_out_i,   // wake-up comparator pin, async
  input wire logic collision_comparator_out_i, // collision comparator pin, async
  input wire logic sdd_done_i,                // detection state machine done, pulse
  output logic [7:0] rdata_o,                 // read data, registered
  output logic rvalid_o,                      // read data valid, pulse
  output ntf_pkg::ntf_cfg_s cfg_o,            // configuration to analog/protocol
  output logic [79:0] target_identifier_o,    // stored identifier bytes
  output logic len_err_o,                     // length field holds prohibited code
  output logic irq_o,                         // interrupt request level
  output logic [7:0] irq_stat_o               // interrupt status code
);
  import ntf_pkg::*;

  function automatic logic [3:0] id_len(input logic [1:0] code);
    unique case (code)
      2'b00: id_len = 4'd4;
      2'b01: id_len = 4'd7;
      2'b10: id_len = 4'd10;
      default: id_len = 4'd0;
    endcase
  endfunction

  logic [1:0] en_s_r, wk_s_r, cl_s_r;
  logic [7:0] coll_r, coll_nxt, wake_r, wake_nxt;
  logic [7:0] id_r [NTF_ID_MAX];
  logic [7:0] id_nxt [NTF_ID_MAX];
  logic [3:0] idx_r, idx_nxt;
  logic prev_cont_r, prev_cont_nxt, field_r, field_nxt;
  logic [7:0] rdata_nxt, irqs_nxt;
  logic rvalid_nxt, irq_nxt;
  logic en_ok, field_now;

  assign en_ok = en_s_r[1];
  assign field_now = (wake_r[2:0] != 3'd0) && wk_s_r[1];

  // pins cross two flops; only stage two is read, so no metastable fan-out

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_s_r <= 2'b00;
      wk_s_r <= 2'b00;
      cl_s_r <= 2'b00;
    end else if (ce_i) begin
      en_s_r <= {en_s_r[0], chip_en_i};
      wk_s_r <= {wk_s_r[0], wakeup_comparator_out_i};
      cl_s_r <= {cl_s_r[0], collision_comparator_out_i};
    end
  end

  always_comb begin
    coll_nxt = coll_r;
    wake_nxt = wake_r;
    idx_nxt = idx_r;
    prev_cont_nxt = req_i.cont;
    for (int i = 0; i < NTF_ID_MAX; i++) begin
      id_nxt[i] = id_r[i];
    end
    if (req_i.wr && req_i.addr == NTF_OFS_COLL) begin
      coll_nxt = req_i.data;
    end
    if (req_i.wr && req_i.addr == NTF_OFS_WAKE) begin
      wake_nxt = req_i.data;
    end
    if (!req_i.cont || !prev_cont_r) begin
      idx_nxt = 4'd0;
    end
    // burst bytes fill successive slots; bytes past the length are dropped, but the 4-bit index wraps so burst byte 17 refills slot 0
    if (req_i.wr && req_i.addr == NTF_OFS_ID) begin
      if (idx_nxt < id_len(wake_r[7:6])) begin
        id_nxt[idx_nxt] = req_i.data;
      end
      idx_nxt = req_i.cont ? 4'(idx_nxt + 4'd1) : 4'd0;
    end
    if (!en_ok || core_por_i) begin
      coll_nxt = NTF_RST_COLL;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      coll_r <= NTF_RST_COLL;
      wake_r <= NTF_RST_WAKE;
      idx_r <= 4'd0;
      prev_cont_r <= 1'b0;
      for (int i = 0; i < NTF_ID_MAX; i++) begin
        id_r[i] <= 8'h00;
      end
    end else if (ce_i) begin
      coll_r <= coll_nxt;
      wake_r <= wake_nxt;
      idx_r <= idx_nxt;
      prev_cont_r <= prev_cont_nxt;
      for (int i = 0; i < NTF_ID_MAX; i++) begin
        id_r[i] <= id_nxt[i];
      end
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    rvalid_nxt = req_i.rd;
    field_nxt = field_now;
    irq_nxt = irq_o;
    irqs_nxt = irq_stat_o;
    unique case (req_i.addr)
      NTF_OFS_COLL: rdata_nxt = coll_r;
      NTF_OFS_ID: rdata_nxt = id_r[0];
      NTF_OFS_WAKE: rdata_nxt = wake_r;
      NTF_OFS_STAT: begin
        rdata_nxt[NTF_BIT_WAKE_CMP] = wk_s_r[1];
        rdata_nxt[NTF_BIT_COLL_CMP] = cl_s_r[1];
      end
      default: rdata_nxt = 8'h00;
    endcase
    if (!req_i.rd) begin
      rdata_nxt = 8'h00;
    end
    // reading the status clears the request; a new event the same cycle wins
    if (req_i.rd && req_i.addr == NTF_OFS_STAT) begin
      irq_nxt = 1'b0;
    end
    if (field_now && !field_r) begin
      irq_nxt = 1'b1;
      irqs_nxt = NTF_IRQ_FIELD;
    end
    if (sdd_done_i && wake_r[NTF_BIT_SDD]) begin
      irq_nxt = 1'b1;
      irqs_nxt = NTF_IRQ_SDD;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
      field_r <= 1'b0;
      irq_o <= 1'b0;
      irq_stat_o <= 8'h00;
      cfg_o <= '0;
      len_err_o <= 1'b0;
      target_identifier_o <= '0;
    end else if (ce_i) begin
      rdata_o <= rdata_nxt;
      rvalid_o <= rvalid_nxt;
      field_r <= field_nxt;
      irq_o <= irq_nxt;
      irq_stat_o <= irqs_nxt;
      cfg_o.clex_dis <= coll_nxt[NTF_BIT_CLEX];
      cfg_o.coll_lvl <= coll_nxt[2:0];
      cfg_o.sdd_en <= wake_nxt[NTF_BIT_SDD];
      cfg_o.extended_rf_range <= wake_nxt[NTF_BIT_HIRF];
      cfg_o.wake_lvl <= wake_nxt[2:0];
      cfg_o.id_bytes <= id_len(wake_nxt[7:6]);
      len_err_o <= wake_nxt[NTF_BIT_LEN_HI] && wake_nxt[NTF_BIT_LEN_LO];
      for (int i = 0; i < NTF_ID_MAX; i++) begin
        target_identifier_o[i*8 +: 8] <= id_nxt[i];
      end
    end
  end

  coll_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !en_ok |=> coll_r == NTF_RST_COLL) else $error("collision level not cleared");
  wake_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !en_ok && !(req_i.wr && req_i.addr == NTF_OFS_WAKE) |=> $stable(wake_r))
    else $error("wake level lost");
  clex_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == NTF_OFS_COLL && en_ok && !core_por_i |=>
    cfg_o.clex_dis == $past(req_i.data[NTF_BIT_CLEX]))
    else $error("clock extractor disable wrong");
  coll_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == NTF_OFS_COLL && en_ok && !core_por_i |=>
    cfg_o.coll_lvl == $past(req_i.data[2:0]))
    else $error("collision threshold not applied");
  stat_live_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.rd && req_i.addr == NTF_OFS_STAT |=> rdata_o[7:6] == $past({wk_s_r[1], cl_s_r[1]}))
    else $error("status comparators wrong");
  len_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == NTF_OFS_WAKE |=>
    cfg_o.id_bytes == ($past(req_i.data[7:6]) == 2'b00 ? 4'd4 :
    $past(req_i.data[7:6]) == 2'b01 ? 4'd7 : $past(req_i.data[7:6]) == 2'b10 ? 4'd10 : 4'd0))
    else $error("length decode wrong");
  len_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == NTF_OFS_WAKE |=>
    len_err_o == ($past(req_i.data[7:6]) == 2'b11))
    else $error("prohibited length not flagged");
  sdd_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == NTF_OFS_WAKE |=>
    cfg_o.sdd_en == $past(req_i.data[NTF_BIT_SDD]))
    else $error("auto detection enable wrong");
  range_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == NTF_OFS_WAKE |=>
    cfg_o.extended_rf_range == $past(req_i.data[NTF_BIT_HIRF]))
    else $error("extended range select wrong");
  wake_lvl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == NTF_OFS_WAKE |=>
    cfg_o.wake_lvl == $past(req_i.data[2:0]))
    else $error("wake threshold not applied");
  sdd_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && sdd_done_i && wake_r[NTF_BIT_SDD] |=> irq_o && irq_stat_o == NTF_IRQ_SDD)
    else $error("detection interrupt missing");
  field_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wake_r[2:0] == 3'd0 && !sdd_done_i |=> irq_stat_o == $past(irq_stat_o))
    else $error("field event with detection off");
  field_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && field_now && !field_r |=>
    irq_o && (irq_stat_o == NTF_IRQ_FIELD || irq_stat_o == NTF_IRQ_SDD))
    else $error("field interrupt missing");
  id_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == NTF_OFS_ID && !prev_cont_r && wake_r[7:6] != 2'b11 |=>
    target_identifier_o[7:0] == $past(req_i.data))
    else $error("identifier not stored");
  id_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == NTF_OFS_ID && wake_r[7:6] == 2'b11 |=>
    target_identifier_o == $past(target_identifier_o))
    else $error("identifier stored with prohibited length");
  wake_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.rd && req_i.addr == NTF_OFS_STAT |=>
    rvalid_o && rdata_o[NTF_BIT_WAKE_CMP] == $past(wk_s_r[1]))
    else $error("wake comparator not reported");

  wake_wr_c: cover property (@(posedge clk_i) req_i.wr && req_i.addr == NTF_OFS_WAKE);
  id_burst_c: cover property (@(posedge clk_i) req_i.wr && req_i.cont && idx_r == 4'd9);
  field_c: cover property (@(posedge clk_i) irq_stat_o == NTF_IRQ_FIELD);
  sdd_c: cover property (@(posedge clk_i) irq_stat_o == NTF_IRQ_SDD);
  len_err_c: cover property (@(posedge clk_i) len_err_o);
endmodule

// ==== tb/ntf_host.sv ====
// host controller model issuing register accesses
`timescale 1ns/1ns
module ntf_host (
  input wire logic clk_i, // core clock
  input wire logic [7:0] rdata_i, // read data from bank
  output ntf_pkg::ntf_req_s req_o // register access
);
  import ntf_pkg::*;
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    req_o = '{1'b1, 1'b0, 1'b0, a, d};
    @(posedge clk_i) #1;
    req_o = '0;
  endtask
  // callers set length in 0x18 first; one unbroken burst, no idle gaps
  task automatic burst(input int n, input logic [79:0] id);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i) #1;
      req_o = '{1'b1, 1'b0, 1'b1, NTF_OFS_ID, id[8*i +: 8]};
    end
    @(posedge clk_i) #1;
    req_o = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i) #1;
    req_o = '{1'b0, 1'b1, 1'b0, a, 8'h00};
    @(posedge clk_i) #1;
    req_o = '0;
    d = rdata_i;
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the target field configuration bank
`timescale 1ns/1ns
module testbench;
  import ntf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic core_por = 1'b0;
  logic chip_en = 1'b1;
  logic wk = 1'b0;
  logic cl = 1'b0;
  logic sdd_done = 1'b0;
  logic ce = 1'b1;
  ntf_req_s req;
  ntf_cfg_s cfg;
  logic [7:0] rdata, irq_stat, v;
  logic [79:0] tid;
  logic rvalid, len_err, irq;
  int n_errors = 0;
  int checks_done = 0;
  always #4 clk_i = ~clk_i;
  ntf_top ntf_top_i (.clk_i(clk_i), .rst_i(rst_i), .core_por_i(core_por), .chip_en_i(chip_en),
    .ce_i(ce), .req_i(req), .wakeup_comparator_out_i(wk), .collision_comparator_out_i(cl),
    .sdd_done_i(sdd_done), .rdata_o(rdata), .rvalid_o(rvalid), .cfg_o(cfg),
    .target_identifier_o(tid), .len_err_o(len_err), .irq_o(irq), .irq_stat_o(irq_stat));
  ntf_host ntf_host_i (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
    ntf_host_i.rd(a, v);
    check("rvalid", {7'h0, rvalid}, 8'h01);
    check($sformatf("reg %h", a), v, e);
  endtask
  // irq waits for the comparator synchroniser, so bounded not fixed
  task automatic wait_irq(input logic [7:0] e);
    int i;
    for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk_i) #1;
    if (i == 20) begin
      n_errors++;
      complete_run();
    end else check("irq_stat", irq_stat, e);
  endtask
  task automatic t_enable();
    ntf_host_i.wr(NTF_OFS_WAKE, 8'h6b);
    chip_en = 1'b0;
    repeat (4) @(posedge clk_i) #1;
    chip_en = 1'b1;
    repeat (3) @(posedge clk_i) #1;
    reg_is(NTF_OFS_COLL, 8'h00);
    reg_is(NTF_OFS_WAKE, 8'h6b);
    ntf_host_i.wr(NTF_OFS_COLL, 8'h03);
    core_por = 1'b1;
    @(posedge clk_i) #1;
    core_por = 1'b0;
    reg_is(NTF_OFS_COLL, 8'h00);
    reg_is(NTF_OFS_WAKE, 8'h6b);
  endtask
  task automatic t_length();
    logic [7:0] nb [3] = '{8'h04, 8'h07, 8'h0a};
    for (int c = 0; c < 3; c++) begin
      ntf_host_i.wr(NTF_OFS_WAKE, {c[1:0], 6'h00});
      check("id_bytes", {4'h0, cfg.id_bytes}, nb[c]);
    end
    ntf_host_i.wr(NTF_OFS_WAKE, 8'hc0);
    check("len_err", {7'h0, len_err}, 8'h01);
    ntf_host_i.wr(NTF_OFS_WAKE, 8'h6b);
    check("len_err", {7'h0, len_err}, 8'h00);
    check("sdd_en", {7'h0, cfg.sdd_en}, 8'h01);
    check("ext_range", {7'h0, cfg.extended_rf_range}, 8'h01);
    check("wake_lvl", {5'h0, cfg.wake_lvl}, 8'h03);
  endtask
  task automatic t_ident();
    logic [79:0] id = 80'h0a_09_08_07_06_05_04_03_02_c1;
    ntf_host_i.burst(7, id);
    for (int i = 0; i < 7; i++) check("id byte", tid[8*i +: 8], id[8*i +: 8]);
    reg_is(NTF_OFS_ID, 8'hc1);
    ntf_host_i.wr(NTF_OFS_WAKE, 8'hc0);
    ntf_host_i.wr(NTF_OFS_ID, 8'h55);
    check("id dropped", tid[7:0], 8'hc1);
    ntf_host_i.wr(NTF_OFS_WAKE, 8'h6b);
  endtask
  task automatic t_freeze();
    ce = 1'b0;
    ntf_host_i.wr(NTF_OFS_COLL, 8'h85);
    ce = 1'b1;
    check("frozen clex_dis", {7'h0, cfg.clex_dis}, 8'h00);
    reg_is(NTF_OFS_COLL, 8'h00);
  endtask
  task automatic t_status();
    wk = 1'b1;
    cl = 1'b1;
    wait_irq(NTF_IRQ_FIELD);
    reg_is(NTF_OFS_STAT, 8'hc0);
    check("irq clear", {7'h0, irq}, 8'h00);
    wk = 1'b0;
    cl = 1'b0;
    repeat (4) @(posedge clk_i) #1;
    reg_is(NTF_OFS_STAT, 8'h00);
    sdd_done = 1'b1;
    @(posedge clk_i) #1;
    sdd_done = 1'b0;
    wait_irq(NTF_IRQ_SDD);
    reg_is(NTF_OFS_STAT, 8'h00);
    ntf_host_i.wr(NTF_OFS_WAKE, 8'h60);
    wk = 1'b1;
    repeat (6) @(posedge clk_i) #1;
    check("irq off", {7'h0, irq}, 8'h00);
    wk = 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    reg_is(NTF_OFS_COLL, NTF_RST_COLL);
    reg_is(NTF_OFS_WAKE, NTF_RST_WAKE);
    reg_is(8'h30, 8'h00);
    ntf_host_i.wr(NTF_OFS_COLL, 8'h85);
    check("clex_dis", {7'h0, cfg.clex_dis}, 8'h01);
    check("coll_lvl", {5'h0, cfg.coll_lvl}, 8'h05);
    reg_is(NTF_OFS_COLL, 8'h85);
    t_enable();
    t_length();
    t_ident();
    t_status();
    t_freeze();
    complete_run();
  end
endmodule
